// ===== uart9_consts.svh
// Register offsets, field positions, response codes and rate constants of the serial port.
// Assumes inclusion by bare name; definitions only.
`ifndef UART9_CONSTS_SVH
`define UART9_CONSTS_SVH
// Register byte offsets on the register bus
`define UART9_OFF_CTRL 5'h00
`define UART9_OFF_BUF 5'h04
`define UART9_OFF_PWR 5'h08
`define UART9_OFF_SLAVE_ADDRESS 5'h0C
`define UART9_OFF_SMASK 5'h10
`define UART9_OFF_T1CFG 5'h14
`define UART9_ADDR_W 5
// Field positions
`define UART9_PWR_DBL 7
`define UART9_PWR_FESEL 6
`define UART9_T1_FAST 8
// Rates: oversampling, fixed-mode divider, timer prescale; then receive idle shift and response codes
`define UART9_OVERSAMPLE 16
`define UART9_M2_DIV 64
`define UART9_T1_PRESCALE 12
`define UART9_RX_IDLE_SHIFT 9'h1FF
`define UART9_RESP_OKAY 2'h0
`define UART9_RESP_SLVERR 2'h2
`endif

// ===== uart9_pkg.sv
// Types of the serial port: receive states and the state records of each module.
// Assumes nothing beyond a SystemVerilog tool.
`default_nettype none
package uart9_pkg;
	// Receiver phases
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_BITS = 2'b01, RX_STOP = 2'b10} uart9_rx_t;
	// Rate generator state
	typedef struct packed {
		logic [1:0] fix_cnt;
		logic [3:0] pre_cnt;
		logic [7:0] t1;
		logic half;
		logic tick;
	} uart9_baud_t;
	// Pin synchroniser state
	typedef struct packed {
		logic meta;
		logic sync;
	} uart9_sync_t;
	// Core state: bus slave, registers, transmitter, receiver
	typedef struct packed {
		logic aw_full; logic [2:0] aw_idx; logic w_full; logic [8:0] wdata; logic [1:0] wstrb;
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [1:0] rresp; logic [8:0] rdata;
		logic sm0; logic fe; logic sm1; logic sm2; logic ren; logic tb8; logic rb8;
		logic ti; logic ri; logic baud_doubler; logic framing_error_select;
		logic [7:0] slave_address; logic [7:0] slave_address_mask; logic [7:0] th1; logic timer1_fast_count; logic [7:0] rx_buf;
		logic tx_req; logic tx_send; logic tx_data_on; logic tx_first; logic [8:0] tx_shift;
		logic [3:0] tx_div; logic txd;
		uart9_rx_t rx_state; logic [3:0] rx_div; logic rx_prev; logic rx_s7; logic rx_s8;
		logic [8:0] rx_shift;
	} uart9_core_t;
endpackage : uart9_pkg
`default_nettype wire

// ===== uart9_link_if.sv
// Carrier between the core, the rate generator and the pin synchroniser.
// Assumes all three run on one clock.
`default_nettype none
interface uart9_link_if;
	logic ce; // Clock enable, freezes state
	logic timer_mode; // Rate from timer overflow
	logic fixed_mode; // Rate from system clock
	logic baud_doubler; // Rate doubler
	logic fast; // Timer prescale bypass
	logic [7:0] reload; // Timer reload value
	logic tick16; // One pulse per sixteenth of a bit
	logic rxd; // Synchronised receive line
	modport baud_mp (input ce, timer_mode, fixed_mode, baud_doubler, fast, reload, output tick16);
	modport sync_mp (input ce, output rxd);
	modport core_mp (output ce, timer_mode, fixed_mode, baud_doubler, fast, reload,
		input tick16, rxd);
endinterface : uart9_link_if
`default_nettype wire

// ===== uart9_sync.sv
// Two-flop synchroniser for the serial input pin.
// Assumes the pin is asynchronous to aclk and idles high.
`default_nettype none
module uart9_sync
	import uart9_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic serial_in,
	uart9_link_if.sync_mp lk
);
	uart9_sync_t q, d;
	// First stage feeds only the second
	always_comb
	begin
		d = q;
		d.meta = serial_in;
		d.sync = q.meta;
	end
	// Reset to idle line level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '{meta: 1'b1, sync: 1'b1};
		else if (lk.ce)
			q <= d;
	end
	assign lk.rxd = q.sync;
endmodule : uart9_sync
`default_nettype wire

// ===== uart9_baud.sv
// Sixteen-times bit rate generator: fixed divider or timer-1 overflow.
// Assumes mode selects come from registers on the same clock.
`default_nettype none
`include "uart9_consts.svh"
module uart9_baud
	import uart9_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	uart9_link_if.baud_mp lk
);
	uart9_baud_t q, d;
	logic [1:0] fix_last;
	logic step;
	// Pulse generation per rate source
	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		fix_last = 2'((`UART9_M2_DIV >> lk.baud_doubler) / `UART9_OVERSAMPLE - 1);
		step = lk.fast || (q.pre_cnt == 4'(`UART9_T1_PRESCALE - 1));
		if (lk.fixed_mode)
		begin
			// Sysclk/64 or /32 per bit, sixteen ticks each
			d.fix_cnt = (q.fix_cnt >= fix_last) ? 2'h0 : q.fix_cnt + 2'h1;
			d.tick = (q.fix_cnt >= fix_last);
		end
		else if (lk.timer_mode)
		begin
			// Prescale by 12 unless fast count is set
			d.pre_cnt = step ? 4'h0 : q.pre_cnt + 4'h1;
			if (step)
			begin
				if (q.t1 == 8'hFF)
				begin
					// Overflow: reload, halve rate unless doubled
					d.t1 = lk.reload;
					d.half = !q.half;
					d.tick = lk.baud_doubler || q.half;
				end
				else
					d.t1 = q.t1 + 8'h01;
			end
		end
	end
	// State register, frozen by clock enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else if (lk.ce)
			q <= d;
	end
	assign lk.tick16 = q.tick;
endmodule : uart9_baud
`default_nettype wire

// ===== uart9_core.sv
// Nine-bit serial port with address recognition behind an AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low reset, and a clock enable
// that freezes every flip-flop including the bus slave.
`default_nettype none
`include "uart9_consts.svh"

module uart9_core
	import uart9_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [`UART9_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`UART9_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in,
	output logic serial_out
);
	import uart9_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Byte match where zero bits of care are ignored
	function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] pat,
		input logic [7:0] care);
		addr_hit = &(~care | ~(b ^ pat));
	endfunction : addr_hit

	// Word index of a register offset
	function automatic logic [2:0] reg_idx(input logic [`UART9_ADDR_W-1:0] off);
		reg_idx = off[4:2];
	endfunction : reg_idx

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------

	uart9_link_if lk ();
	uart9_core_t q, d;
	logic [1:0] mode; // Mode number from the two select bits
	logic tick; // Sixteenth-bit pulse
	logic rxd; // Synchronised receive line
	logic do_wr; // Address and data both held
	logic wr_ctrl; // Low byte write of control register
	logic roll; // Transmit bit-time rollover
	logic last; // Transmit end condition
	logic bitv; // Majority-voted receive bit
	logic [7:0] rbyte; // Received byte in natural order
	logic addr_ok; // Given or broadcast match
	logic load_ok; // Receive buffer load decision

	uart9_baud u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.lk(lk.baud_mp)
	);

	uart9_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.serial_in(serial_in),
		.lk(lk.sync_mp)
	);

	assign mode = {q.sm0, q.sm1};
	assign lk.ce = clk_en;
	assign lk.fixed_mode = (mode == 2'd2);
	assign lk.timer_mode = mode[0]; // Modes 1 and 3
	assign lk.baud_doubler = q.baud_doubler;
	assign lk.fast = q.timer1_fast_count;
	assign lk.reload = q.th1;
	assign tick = lk.tick16;
	assign rxd = lk.rxd;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Bus slave first, then hardware events so that sets beat clears
	always_comb
	begin
		d = q;
		do_wr = q.aw_full && q.w_full && !q.bvalid;
		wr_ctrl = do_wr && q.wstrb[0] && (q.aw_idx == reg_idx(`UART9_OFF_CTRL));
		roll = tick && (q.tx_div == 4'(`UART9_OVERSAMPLE - 1));
		last = 1'b0;
		bitv = 1'b0;
		rbyte = 8'h00;
		addr_ok = 1'b0;
		load_ok = 1'b0;

		// Write address and data are taken independently
		if (s_axi_awvalid && q.awready)
		begin
			d.aw_full = 1'b1;
			d.aw_idx = reg_idx(s_axi_awaddr);
		end
		if (s_axi_wvalid && q.wready)
		begin
			d.w_full = 1'b1;
			d.wdata = s_axi_wdata[8:0];
			d.wstrb = s_axi_wstrb[1:0];
		end
		// Response retires on its handshake
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;

		// Register write decode
		if (do_wr)
		begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `UART9_RESP_OKAY;
			if (q.aw_idx == reg_idx(`UART9_OFF_CTRL))
			begin
				if (wr_ctrl)
				begin
					// Top bit is the error flag or a mode bit
					if (q.framing_error_select)
						d.fe = q.wdata[7]; // Only software clears it
					else
						d.sm0 = q.wdata[7];
					d.sm1 = q.wdata[6];
					d.sm2 = q.wdata[5];
					d.ren = q.wdata[4];
					d.tb8 = q.wdata[3];
					d.rb8 = q.wdata[2];
					d.ti = q.wdata[1];
					d.ri = q.wdata[0];
				end
			end
			else if (q.aw_idx == reg_idx(`UART9_OFF_BUF))
				d.bresp = `UART9_RESP_OKAY; // Transmit load handled below
			else if (q.aw_idx == reg_idx(`UART9_OFF_PWR))
			begin
				if (q.wstrb[0])
				begin
					d.baud_doubler = q.wdata[`UART9_PWR_DBL];
					d.framing_error_select = q.wdata[`UART9_PWR_FESEL];
				end
			end
			else if (q.aw_idx == reg_idx(`UART9_OFF_SLAVE_ADDRESS))
			begin
				if (q.wstrb[0])
					d.slave_address = q.wdata[7:0];
			end
			else if (q.aw_idx == reg_idx(`UART9_OFF_SMASK))
			begin
				if (q.wstrb[0])
					d.slave_address_mask = q.wdata[7:0];
			end
			else if (q.aw_idx == reg_idx(`UART9_OFF_T1CFG))
			begin
				if (q.wstrb[0])
					d.th1 = q.wdata[7:0];
				if (q.wstrb[1])
					d.timer1_fast_count = q.wdata[`UART9_T1_FAST];
			end
			else
				d.bresp = `UART9_RESP_SLVERR; // Unmapped word
		end
		d.awready = !d.aw_full && !d.bvalid;
		d.wready = !d.w_full && !d.bvalid;

		// Read: one outstanding, answer one cycle after the address
		if (s_axi_arvalid && q.arready)
		begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = `UART9_RESP_OKAY;
			d.rdata = 9'h000;
			if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_CTRL))
				d.rdata = {1'b0, (q.framing_error_select ? q.fe : q.sm0), q.sm1, q.sm2, q.ren,
					q.tb8, q.rb8, q.ti, q.ri};
			else if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_BUF))
				d.rdata = {1'b0, q.rx_buf};
			else if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_PWR))
				d.rdata = {1'b0, q.baud_doubler, q.framing_error_select, 6'h00};
			else if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_SLAVE_ADDRESS))
				d.rdata = {1'b0, q.slave_address};
			else if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_SMASK))
				d.rdata = {1'b0, q.slave_address_mask};
			else if (reg_idx(s_axi_araddr) == reg_idx(`UART9_OFF_T1CFG))
				d.rdata = {q.timer1_fast_count, q.th1};
			else
				d.rresp = `UART9_RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end

		// Transmit bit-time counter runs free on the sixteenth ticks
		if (tick)
			d.tx_div = q.tx_div + 4'h1;
		if (roll)
		begin
			if (q.tx_req)
			begin
				// Request taken at rollover, start bit out
				d.tx_req = 1'b0;
				d.tx_send = 1'b1;
			end
			else if (q.tx_send && !q.tx_data_on)
				d.tx_data_on = 1'b1; // Shifter drives the line
			else if (q.tx_data_on)
			begin
				// Ninth bit at output, stop behind it, zeros beyond
				// Mode 3 frames like mode 2; only mode 1 preloads its stop bit
				last = ((mode == 2'd1) || q.tx_first) && (q.tx_shift[8:1] == 8'h01);
				// First nine-bit shift inserts the stop bit
				d.tx_shift = {(mode != 2'd1) && !q.tx_first, q.tx_shift[8:1]};
				d.tx_first = 1'b1;
				if (last)
				begin
					d.tx_send = 1'b0;
					d.tx_data_on = 1'b0;
					d.ti = 1'b1;
				end
			end
		end
		// Buffer write loads the shifter and the ninth bit
		if (do_wr && q.wstrb[0] && (q.aw_idx == reg_idx(`UART9_OFF_BUF)))
		begin
			d.tx_shift = {(mode[0] && !mode[1]) ? 1'b1 : q.tb8, q.wdata[7:0]};
			d.tx_req = 1'b1;
			d.tx_send = 1'b0;
			d.tx_data_on = 1'b0;
			d.tx_first = 1'b0;
		end
		// Idle high, start low, then shifter output
		d.txd = !d.tx_send || (d.tx_data_on && d.tx_shift[0]);

		// Receiver, stepped by the sixteen-times sample tick
		if (tick)
		begin
			d.rx_prev = rxd;
			if (q.rx_state == RX_IDLE)
			begin
				// Falling edge only while enabled, not in shift mode
				if (q.ren && (mode != 2'd0) && q.rx_prev && !rxd)
				begin
					d.rx_state = RX_BITS;
					d.rx_div = 4'h0;
					d.rx_shift = `UART9_RX_IDLE_SHIFT;
				end
			end
			else
			begin
				d.rx_div = q.rx_div + 4'h1;
				if (q.rx_div == 4'h7)
					d.rx_s7 = rxd;
				if (q.rx_div == 4'h8)
					d.rx_s8 = rxd;
				if (q.rx_div == 4'h9)
				begin
					// Two of three samples decide the bit
					bitv = (q.rx_s7 & q.rx_s8) | (q.rx_s7 & rxd) | (q.rx_s8 & rxd);
					if (q.rx_state == RX_STOP)
					begin
						// Stop affects only the error flag
						if (!bitv)
							d.fe = 1'b1;
						d.rx_state = RX_IDLE;
					end
					else if ((q.rx_shift == `UART9_RX_IDLE_SHIFT) && bitv)
						d.rx_state = RX_IDLE; // False start rejected
					else
					begin
						// Shift in from the right, ones leave on the left
						d.rx_shift = {q.rx_shift[7:0], bitv};
						if (!q.rx_shift[8])
						begin
							// Start bit at leftmost: final shift
							for (int i = 0; i < 8; i++)
								rbyte[i] = q.rx_shift[7 - i];
							// Given and broadcast patterns
							addr_ok = addr_hit(rbyte, q.slave_address & q.slave_address_mask, q.slave_address_mask) ||
								addr_hit(rbyte, q.slave_address | q.slave_address_mask, q.slave_address | q.slave_address_mask);
							// Final bit is ninth bit, or stop in mode 1
							load_ok = !q.ri && (!q.sm2 || (bitv && addr_ok));
							if (load_ok)
							begin
								d.rx_buf = rbyte;
								d.rb8 = bitv;
								d.ri = 1'b1;
							end
							if (mode == 2'd1)
							begin
								if (!bitv)
									d.fe = 1'b1;
								d.rx_state = RX_IDLE;
							end
							else
								d.rx_state = RX_STOP;
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Synchronous reset; address and mask clear to zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, txd: 1'b1, rx_prev: 1'b1,
				rx_state: RX_IDLE, default: '0};
		else if (clk_en)
			q <= d;
	end

	// Outputs straight from flops
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = {23'h000000, q.rdata};
	assign serial_out = q.txd;
endmodule : uart9_core
`default_nettype wire

// ===== uart9_core_properties.sv
// Concurrent checks on the serial port's register bus and transmit line.
// Assumes one clock aclk, synchronous active-low aresetn, clk_en mostly high.
`default_nettype none
`include "uart9_consts.svh"
module uart9_core_properties
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [`UART9_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----
	// Handshake steps
	// ----
	// Both write channels taken, then one running cycle to register
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en ##1 clk_en;
	endsequence
	// Read address taken while running
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready && clk_en;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
		else $error("write response not raised on time");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read data not raised on time");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data changed before taken");
	a_unmapped_err: assert property ((s_rd_taken and s_axi_araddr[4:3] == 2'h3)
		|=> s_axi_rresp == `UART9_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_mapped_okay: assert property ((s_rd_taken and s_axi_araddr[4:3] != 2'h3)
		|=> s_axi_rresp == `UART9_RESP_OKAY)
		else $error("mapped read refused");
	a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
		else $error("read data has upper bits set");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	// Fastest rate still gives sixteen clocks a bit, so eight is a safe floor
	a_bit_width: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
		else $error("serial bit shorter than allowed");
endmodule : uart9_core_properties
bind uart9_core uart9_core_properties chk (.aclk, .aresetn, .clk_en, .s_axi_araddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .serial_out);
`default_nettype wire

// ===== uart9_far_node.sv
// Remote node on the serial line: sends nine-bit frames and decodes frames it hears.
// Assumes mode 2 at BIT_CLKS clocks a bit; its line idles high between frames.
`default_nettype none
module uart9_far_node
#(
	parameter int BIT_CLKS = 64 // Clocks a bit, fixed rate undoubled
)
(
	input wire logic aclk,
	input wire logic line_in,
	output var logic line_out,
	output var logic [9:0] got,
	output var logic got_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle line high until a frame is sent
	initial
	begin
		line_out = 1'b1;
		got = 10'h000;
		got_stb = 1'b0;
	end
	// Start, eight data LSB first, ninth, stop; master marks addresses by ninth
	task automatic send(input logic [7:0] d, input logic nb, input logic sb);
		logic [10:0] f;
		f = {sb, nb, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge aclk);
			line_out <= f[i];
			repeat (BIT_CLKS - 1) @(posedge aclk);
		end
		@(posedge aclk);
		line_out <= 1'b1;
	endtask : send
	// Short low pulse, too short to pass as a start bit
	task automatic glitch(input int n);
		@(posedge aclk);
		line_out <= 1'b0;
		repeat (n) @(posedge aclk);
		line_out <= 1'b1;
	endtask : glitch
	// Mid-bit sampling of the device's frames; reports stop, ninth and data
	always
	begin : rx_side
		logic [10:0] fr;
		@(negedge line_in);
		repeat (BIT_CLKS / 2) @(posedge aclk);
		for (int i = 0; i < 11; i++)
		begin
			fr[i] = line_in;
			if (i < 10)
				repeat (BIT_CLKS) @(posedge aclk);
		end
		got <= fr[10:1];
		got_stb <= 1'b1;
		@(posedge aclk);
		got_stb <= 1'b0;
	end
endmodule : uart9_far_node
`default_nettype wire

// ===== uart_nine_bit_addr_recognition_tb_top.sv
// Self-checking bench: bus tasks drive the core, a monitor checks queued results.
// Assumes the core runs modes 2 and 3 at 64 clocks a bit against the far node.
`default_nettype none
`include "uart9_consts.svh"
module uart_nine_bit_addr_recognition_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] o_ctl = `UART9_OFF_CTRL;
	localparam logic [4:0] o_buf = `UART9_OFF_BUF;
	localparam logic [1:0] r_ok = `UART9_RESP_OKAY;
	localparam logic [1:0] r_er = `UART9_RESP_SLVERR;
	logic aclk, aresetn, clk_en, serial_in, serial_out, got_stb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [`UART9_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [9:0] got;
	logic [33:0] exp_q[$]; // Expected response and data, oldest first
	string nm_q[$]; // Names of the pending checks
	logic [9:0] fr_q[$]; // Expected frames heard by the far node
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] seed = 32'h00008E57;
	uart9_core uut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_out);
	uart9_far_node far (.aclk, .line_in(serial_out), .line_out(serial_in), .got, .got_stb);
	// 200 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Xorshift source; fixed seed keeps runs repeatable
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic take(input string nm, input logic [33:0] ex, input logic [33:0] seen);
		n_compared++;
		if (seen !== ex)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask : take
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] rs);
		logic aw;
		logic w;
		exp_q.push_back({rs, 32'h0});
		nm_q.push_back("write response");
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			aw = aw || (s_axi_awvalid && s_axi_awready);
			w = w || (s_axi_wvalid && s_axi_wready);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	// Read: ready raised late so the slave must hold its answer
	task automatic rd(input logic [4:0] a, input logic [1:0] rs, input logic [31:0] d, string nm);
		exp_q.push_back({rs, d});
		nm_q.push_back(nm);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// Monitor: oldest note is taken off whenever a result appears
	always @(posedge aclk)
	begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			take(nm_q.pop_front(), exp_q.pop_front(), {s_axi_bresp, 32'h0});
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			take(nm_q.pop_front(), exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (got_stb === 1'b1)
			take("frame", {24'h0, fr_q.pop_front()}, {24'h0, got});
	end
	// Watchdog well beyond the dozen frames of the run
	initial
	begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		logic [31:0] d;
		logic [31:0] e;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		clk_en = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(o_ctl, r_ok, 32'h0, "control");
		rd(`UART9_OFF_SLAVE_ADDRESS, r_ok, 32'h0, "address");
		rd(`UART9_OFF_SMASK, r_ok, 32'h0, "mask");
		rd(5'h18, r_er, 32'h0, "unmapped");
		wr(5'h1C, 32'h0, r_er);
		$display("Test reset and unmapped done");
		// Mode 2 transmit with ninth bit set
		d = rnd();
		wr(o_ctl, 32'h98, r_ok);
		fr_q.push_back({2'h3, d[7:0]});
		wr(o_buf, d, r_ok);
		wait (got_stb === 1'b1);
		repeat (80) @(posedge aclk);
		rd(o_ctl, r_ok, 32'h9A, "control");
		$display("Test transmit done");
		// Plain receive, then a frame lost while the flag is still set
		wr(o_ctl, 32'h90, r_ok);
		d = rnd();
		far.send(d[7:0], 1'b1, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		rd(o_ctl, r_ok, 32'h95, "control");
		e = rnd();
		far.send(e[7:0], 1'b0, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		$display("Test receive done");
		// Address recognition with a masked slave address
		wr(`UART9_OFF_SLAVE_ADDRESS, 32'hC0, r_ok);
		wr(`UART9_OFF_SMASK, 32'hFD, r_ok);
		wr(o_ctl, 32'hB0, r_ok);
		far.send(8'hC2, 1'b0, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		far.send(8'hC1, 1'b1, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		far.send(8'hC2, 1'b1, 1'b1);
		rd(o_buf, r_ok, 32'hC2, "buffer");
		wr(o_ctl, 32'hB0, r_ok);
		far.send(8'hFD, 1'b1, 1'b1);
		rd(o_buf, r_ok, 32'hFD, "buffer");
		$display("Test address done");
		// Missing stop bit; flag then survives a later frame
		wr(`UART9_OFF_PWR, 32'h40, r_ok);
		wr(o_ctl, 32'h10, r_ok);
		d = rnd();
		far.send(d[7:0], 1'b0, 1'b0);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		rd(o_ctl, r_ok, 32'h91, "control");
		far.send(e[7:0], 1'b1, 1'b1);
		rd(o_ctl, r_ok, 32'h91, "control");
		$display("Test framing done");
		// False start rejected, next frame caught; disabled receiver ignores one
		wr(o_ctl, 32'h10, r_ok);
		far.glitch(20);
		repeat (100) @(posedge aclk);
		d = rnd();
		far.send(d[7:0], 1'b1, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		wr(o_ctl, 32'h00, r_ok);
		far.send(e[7:0], 1'b1, 1'b1);
		rd(o_buf, r_ok, {24'h0, d[7:0]}, "buffer");
		$display("Test start edge done");
		// Timer-driven mode 3: fast count, reload FE gives 64 clocks a bit
		wr(`UART9_OFF_PWR, 32'h00, r_ok);
		wr(`UART9_OFF_T1CFG, 32'h1FE, r_ok);
		wr(o_ctl, 32'hC8, r_ok);
		d = rnd();
		fr_q.push_back({2'h3, d[7:0]});
		wr(o_buf, d, r_ok);
		wait (got_stb === 1'b1);
		repeat (80) @(posedge aclk);
		rd(o_ctl, r_ok, 32'hCA, "control");
		rd(`UART9_OFF_T1CFG, r_ok, 32'h1FE, "timer");
		$display("Test timer mode done");
		complete_run();
	end
endmodule : uart_nine_bit_addr_recognition_tb_top
`default_nettype wire
